// ---- posp_core.sv ----
// Decode and execute of parallel OR-with-store and the two stack pops
`timescale 1ns/1ns
`default_nettype none
module posp_core #(
  parameter int NUM_REGS = 28
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_mem_rd_data,
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic [39:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic             o_busy,
  output logic             o_mem_rd_en,
  output logic [31:0]      o_mem_rd_addr,
  output logic             o_mem_wr_en,
  output logic [31:0]      o_mem_wr_addr,
  output logic [31:0]      o_mem_wr_data,
  output logic             o_done,
  output logic             o_illegal,
  output logic [39:0]      o_reg_rdata,
  output logic [6:0]       o_flags
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_REGS != 28) begin : g_bad_regs
    $error("posp_core: NUM_REGS must be 28");
  end

  if (posp_pkg::LAST_REG != 5'(NUM_REGS - 1)) begin : g_bad_layout
    $error("posp_core: register count and package layout disagree");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    posp_pkg::posp_fsm_t          fsm;
    posp_pkg::posp_kind_t         kind;
    logic [NUM_REGS-1:0][39:0]    regs;
    logic [6:0]                   flags;
    logic [31:0]                  instr;
    logic                         ar_a_we;
    logic [2:0]                   ar_a_idx;
    logic [31:0]                  ar_a_val;
    logic                         ar_b_we;
    logic [2:0]                   ar_b_idx;
    logic [31:0]                  ar_b_val;
    logic [31:0]                  st_addr;
    logic                         busy;
    logic                         rd_en;
    logic [31:0]                  rd_addr;
    logic                         wr_en;
    logic [31:0]                  wr_addr;
    logic [31:0]                  wr_data;
    logic                         done;
    logic                         illegal;
    logic [39:0]                  rdata;
  } posp_state_t;

  posp_state_t s_ff;
  posp_state_t nxt_s;

  // ----------------------------------------------------------------
  // Indirect address: returns {effective address, updated aux value}
  // ----------------------------------------------------------------
  function automatic logic [63:0] ind_calc(input logic [7:0]  fld,
                                           input logic [31:0] arv,
                                           input logic [31:0] idx0,
                                           input logic [31:0] idx1);
    logic [31:0] disp;
    logic [31:0] plus;
    logic [31:0] minus;
    logic [63:0] res;
    // Displacement limited to zero, one or an index register
    // (RL4) displacement select
    case (fld[4:3])
      posp_pkg::DISP_ZERO:   disp = 32'h0000_0000;
      posp_pkg::DISP_ONE:    disp = 32'h0000_0001;
      posp_pkg::DISP_INDEX0: disp = idx0;
      default:               disp = idx1;
    endcase
    plus  = arv + disp;
    minus = arv - disp;
    case (fld[7:5])
      posp_pkg::IND_PRE_ADD:     res = {plus, arv};
      posp_pkg::IND_PRE_SUB:     res = {minus, arv};
      posp_pkg::IND_PRE_ADD_MOD: res = {plus, plus};
      posp_pkg::IND_PRE_SUB_MOD: res = {minus, minus};
      posp_pkg::IND_POST_ADD:    res = {arv, plus};
      posp_pkg::IND_POST_SUB:    res = {arv, minus};
      default:                   res = {arv, arv};
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] idx0;
    logic [31:0] idx1;
    logic [31:0] stk;
    logic [63:0] src_calc;
    logic [63:0] dst_calc;
    logic [2:0]  src_ar;
    logic [2:0]  dst_ar;
    logic [4:0]  pop_dst;
    logic [2:0]  or_dst;
    logic [2:0]  first_src;
    logic [2:0]  store_src;
    logic [31:0] or_res;
    logic [31:0] word;
    logic        is_par;
    logic        is_popi;
    logic        is_fpop;
    // --------------------------------------------------------------
    // Operand decode
    // --------------------------------------------------------------
    idx0      = s_ff.regs[posp_pkg::INDEX0_IDX][31:0];
    idx1      = s_ff.regs[posp_pkg::INDEX1_IDX][31:0];
    stk       = s_ff.regs[posp_pkg::STACK_PTR_IDX][31:0];
    src_ar    = i_instr[2:0];
    dst_ar    = i_instr[10:8];
    src_calc  = ind_calc(i_instr[posp_pkg::SECOND_SRC_MSB -: 8],
                         s_ff.regs[posp_pkg::AUX_BASE + {2'b00, src_ar}][31:0], idx0, idx1);
    dst_calc  = ind_calc(i_instr[posp_pkg::STORE_DST_MSB -: 8],
                         s_ff.regs[posp_pkg::AUX_BASE + {2'b00, dst_ar}][31:0], idx0, idx1);
    pop_dst   = i_instr[posp_pkg::POP_DST_MSB -: 5];
    // (RL3) three-bit register fields
    or_dst    = s_ff.instr[posp_pkg::OR_DST_MSB -: 3];
    first_src = s_ff.instr[posp_pkg::FIRST_SRC_MSB -: 3];
    store_src = s_ff.instr[posp_pkg::STORE_SRC_MSB -: 3];
    word      = i_mem_rd_data;
    or_res    = s_ff.regs[first_src][31:0] | word;

    // --------------------------------------------------------------
    // Instruction match
    // --------------------------------------------------------------
    // (RL1) parallel opcode match
    // (RL2) leading ones and opcode position
    is_par  = (i_instr[31:30] == posp_pkg::PAR_LEAD) && (i_instr[29:25] == posp_pkg::PAR_OPCODE);
    // (RL12) integer pop opcode
    // (RL11) destination 0..27 only
    is_popi = (i_instr[31:21] == posp_pkg::POP_INT_OPCODE) && (i_instr[15:0] == 16'h0000)
              && (pop_dst <= posp_pkg::LAST_REG);
    // (RL13) float pop opcode
    // (RL14) destination 0..7 only
    is_fpop = (i_instr[31:21] == posp_pkg::POP_FLT_OPCODE) && (i_instr[15:0] == 16'h0000)
              && (pop_dst <= posp_pkg::LAST_PRIMARY);

    nxt_s         = s_ff;
    nxt_s.rd_en   = 1'b0;
    nxt_s.wr_en   = 1'b0;
    nxt_s.done    = 1'b0;
    nxt_s.illegal = 1'b0;

    // --------------------------------------------------------------
    // Software register port
    // --------------------------------------------------------------
    // Writes land first, instruction commits override them
    if (i_reg_wr) begin
      if (i_reg_addr <= posp_pkg::LAST_REG) begin
        nxt_s.regs[i_reg_addr] = i_reg_wdata;
      end else if (i_reg_addr == posp_pkg::STATUS_ADDR) begin
        nxt_s.flags = i_reg_wdata[6:0];
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr <= posp_pkg::LAST_REG) begin
        nxt_s.rdata = s_ff.regs[i_reg_addr];
      end else if (i_reg_addr == posp_pkg::STATUS_ADDR) begin
        nxt_s.rdata = {33'h0, s_ff.flags};
      end else begin
        nxt_s.rdata = 40'h00_0000_0000;
      end
    end

    // --------------------------------------------------------------
    // Instruction sequencing
    // --------------------------------------------------------------
    case (s_ff.fsm)
      posp_pkg::ST_IDLE: begin
        if (i_instr_valid && (is_par || is_popi || is_fpop)) begin
          nxt_s.instr = i_instr;
          nxt_s.rd_en = 1'b1;
          nxt_s.busy  = 1'b1;
          nxt_s.fsm   = posp_pkg::ST_EXEC;
          if (is_par) begin
            // (RL4) both memory operands indirect
            nxt_s.kind     = posp_pkg::KIND_PAR;
            nxt_s.rd_addr  = src_calc[63:32];
            nxt_s.st_addr  = dst_calc[63:32];
            nxt_s.ar_a_we  = 1'b1;
            nxt_s.ar_a_idx = src_ar;
            nxt_s.ar_a_val = src_calc[31:0];
            nxt_s.ar_b_we  = 1'b1;
            nxt_s.ar_b_idx = dst_ar;
            nxt_s.ar_b_val = dst_calc[31:0];
          end else begin
            nxt_s.kind     = is_fpop ? posp_pkg::KIND_FPOP : posp_pkg::KIND_POPI;
            nxt_s.rd_addr  = stk;
            nxt_s.st_addr  = 32'h0000_0000;
            nxt_s.ar_a_we  = 1'b0;
            nxt_s.ar_b_we  = 1'b0;
          end
        end else if (i_instr_valid) begin
          // Refused word only pulses; addresses and operand state hold
          nxt_s.illegal = 1'b1;
        end
      end
      posp_pkg::ST_EXEC: begin
        // (RL19) single execute cycle
        nxt_s.fsm  = posp_pkg::ST_IDLE;
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
        // Overflow and underflow always clear on commit
        nxt_s.flags[posp_pkg::FLG_V]     = 1'b0;
        nxt_s.flags[posp_pkg::FLG_UNDER] = 1'b0;
        case (s_ff.kind)
          posp_pkg::KIND_PAR: begin
            // (RL6) operands from state before commit
            // (RL7) store source read before OR write
            nxt_s.wr_en   = 1'b1;
            nxt_s.wr_addr = s_ff.st_addr;
            nxt_s.wr_data = s_ff.regs[store_src][31:0];
            // (RL8) source read this cycle, write next
            // (RL5) OR result into register
            nxt_s.regs[or_dst][31:0] = or_res;
            // Store-side aux update wins when both name one aux register
            if (s_ff.ar_a_we) begin
              nxt_s.regs[posp_pkg::AUX_BASE + {2'b00, s_ff.ar_a_idx}][31:0] = s_ff.ar_a_val;
            end
            if (s_ff.ar_b_we) begin
              nxt_s.regs[posp_pkg::AUX_BASE + {2'b00, s_ff.ar_b_idx}][31:0] = s_ff.ar_b_val;
            end
            // (RL9) OR result flags
            nxt_s.flags[posp_pkg::FLG_N] = or_res[31];
            nxt_s.flags[posp_pkg::FLG_Z] = (or_res == 32'h0000_0000);
          end
          posp_pkg::KIND_POPI: begin
            // (RL15) stack pointer post decrement
            nxt_s.regs[posp_pkg::STACK_PTR_IDX][31:0] = stk - 32'h0000_0001;
            // (RL10) signed word into destination
            nxt_s.regs[s_ff.instr[posp_pkg::POP_DST_MSB -: 5]][31:0] = word;
            // (RL16) integer result flags
            nxt_s.flags[posp_pkg::FLG_N] = word[31];
            nxt_s.flags[posp_pkg::FLG_Z] = (word == 32'h0000_0000);
          end
          posp_pkg::KIND_FPOP: begin
            // (RL15) stack pointer post decrement
            nxt_s.regs[posp_pkg::STACK_PTR_IDX][31:0] = stk - 32'h0000_0001;
            // (RL17) word loaded as floating point
            // (RL18) upper 32 bits, low mantissa cleared
            nxt_s.regs[s_ff.instr[posp_pkg::POP_DST_MSB -: 5]] = {word, 8'h00};
            // (RL16) float result flags
            nxt_s.flags[posp_pkg::FLG_N] = word[31];
            nxt_s.flags[posp_pkg::FLG_Z] = (word[31:24] == posp_pkg::FLOAT_ZERO_EXP);
          end
          default: begin
            nxt_s.done = 1'b0;
          end
        endcase
      end
      default: begin
        nxt_s.fsm  = posp_pkg::ST_IDLE;
        nxt_s.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_busy        = s_ff.busy;
  assign o_mem_rd_en   = s_ff.rd_en;
  assign o_mem_rd_addr = s_ff.rd_addr;
  assign o_mem_wr_en   = s_ff.wr_en;
  assign o_mem_wr_addr = s_ff.wr_addr;
  assign o_mem_wr_data = s_ff.wr_data;
  assign o_done        = s_ff.done;
  assign o_illegal     = s_ff.illegal;
  assign o_reg_rdata   = s_ff.rdata;
  assign o_flags       = s_ff.flags;

endmodule
`default_nettype wire

// ---- posp_pkg.sv ----
// Constants shared by the parallel OR-with-store and stack pop execute block
//
// Function
// (RL1) Parallel OR-with-store found by fixed opcode
// (RL2) Leading ones, opcode, three register fields, addresses
// (RL3) OR and store registers limited to 0..7
// (RL4) Memory operands indirect, displacement 0, 1, index
// (RL5) OR into register, store source to memory
// (RL6) Operands read at start, results at end
// (RL7) Store takes register value before OR commit
// (RL8) Source memory read before store write
// (RL9) OR sets N, Z; clears V, underflow
// (RL10) Integer pop loads stack word, registers 0..27
// (RL11) Integer pop destination accepts registers 0..27
// (RL12) Integer pop opcode fixed, low bits zero
// (RL13) Float pop opcode fixed, low bits zero
// (RL14) Float pop destination limited to 0..7
// (RL15) Both pops decrement stack pointer afterwards
// (RL16) Pops set N, Z; clear V, underflow
// (RL17) Float pop treats word as floating point
// (RL18) Float word in upper 32, low 8 cleared
// (RL19) One execute cycle, saturate setting ignored
package posp_pkg;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  PAR_LEAD       = 2'h3;
  localparam logic [4:0]  PAR_OPCODE     = 5'h14;
  localparam logic [10:0] POP_INT_OPCODE = 11'h071;
  localparam logic [10:0] POP_FLT_OPCODE = 11'h075;
  localparam int          OR_DST_MSB     = 24;
  localparam int          FIRST_SRC_MSB  = 21;
  localparam int          STORE_SRC_MSB  = 18;
  localparam int          STORE_DST_MSB  = 15;
  localparam int          SECOND_SRC_MSB = 7;
  localparam int          POP_DST_MSB    = 20;

  // ----------------------------------------------------------------
  // Register file layout
  // ----------------------------------------------------------------
  localparam logic [4:0]  LAST_PRIMARY   = 5'h07;
  localparam logic [4:0]  LAST_REG       = 5'h1b;
  localparam logic [4:0]  AUX_BASE       = 5'h08;
  localparam logic [4:0]  INDEX0_IDX     = 5'h11;
  localparam logic [4:0]  INDEX1_IDX     = 5'h12;
  localparam logic [4:0]  STACK_PTR_IDX  = 5'h14;
  localparam logic [4:0]  STATUS_ADDR    = 5'h1c;
  localparam logic [7:0]  FLOAT_ZERO_EXP = 8'h80;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam int FLG_C           = 0;
  localparam int FLG_V           = 1;
  localparam int FLG_Z           = 2;
  localparam int FLG_N           = 3;
  localparam int FLG_UNDER       = 4;
  localparam int FLG_LATCH_OVF   = 5;
  localparam int FLG_LATCH_UNDER = 6;

  // ----------------------------------------------------------------
  // Indirect address field: op in [7:5], displacement in [4:3], aux in [2:0]
  // ----------------------------------------------------------------
  localparam logic [1:0] DISP_ZERO   = 2'h0;
  localparam logic [1:0] DISP_ONE    = 2'h1;
  localparam logic [1:0] DISP_INDEX0 = 2'h2;
  localparam logic [2:0] IND_PRE_ADD     = 3'h0;
  localparam logic [2:0] IND_PRE_SUB     = 3'h1;
  localparam logic [2:0] IND_PRE_ADD_MOD = 3'h2;
  localparam logic [2:0] IND_PRE_SUB_MOD = 3'h3;
  localparam logic [2:0] IND_POST_ADD    = 3'h4;
  localparam logic [2:0] IND_POST_SUB    = 3'h5;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_PAR  = 2'b01,
    KIND_POPI = 2'b10,
    KIND_FPOP = 2'b11
  } posp_kind_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } posp_fsm_t;

endpackage

// ---- posp_core_asserts.sv ----
// Port assertions for the OR-with-store and stack pop block
`timescale 1ns/1ns
`default_nettype none
module posp_core_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_mem_rd_data,
  input wire logic [4:0]  i_reg_addr,
  input wire logic [39:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic        o_busy,
  input wire logic        o_mem_rd_en,
  input wire logic [31:0] o_mem_rd_addr,
  input wire logic        o_mem_wr_en,
  input wire logic [31:0] o_mem_wr_addr,
  input wire logic [31:0] o_mem_wr_data,
  input wire logic        o_done,
  input wire logic        o_illegal,
  input wire logic [39:0] o_reg_rdata,
  input wire logic [6:0]  o_flags
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic take;
  assign take = i_instr_valid && !o_busy;

  a_busy_single: assert property (o_busy |=> !o_busy) else $error("busy held too long");
  a_done_follows: assert property (o_busy |=> o_done) else $error("no commit after execute");
  a_read_in_exec: assert property (o_mem_rd_en |-> o_busy) else $error("read outside execute");
  a_store_after_read: assert property (o_mem_wr_en |-> o_done && $past(o_mem_rd_en))
    else $error("store not preceded by read");
  a_par_decode: assert property (take && i_instr[31:25] == {posp_pkg::PAR_LEAD, posp_pkg::PAR_OPCODE}
    |=> o_busy && o_mem_rd_en ##1 o_mem_wr_en) else $error("parallel word not executed");
  a_pop_no_store: assert property (take && i_instr[31:21] == posp_pkg::POP_INT_OPCODE
    && i_instr[15:0] == 16'h0000 && i_instr[20:16] <= 5'h1b |=> o_mem_rd_en ##1 (o_done && !o_mem_wr_en))
    else $error("integer pop misbehaved");
  a_fpop_range: assert property (take && i_instr[31:21] == posp_pkg::POP_FLT_OPCODE
    && i_instr[20:16] > 5'h07 |=> o_illegal && !o_busy) else $error("float pop range not refused");
  a_flags_cleared: assert property (o_done |-> !o_flags[posp_pkg::FLG_V] && !o_flags[posp_pkg::FLG_UNDER])
    else $error("overflow or underflow left set");
  a_flags_kept: assert property (o_done && !$past(i_reg_wr) |-> o_flags[0] == $past(o_flags[0])
    && o_flags[6:5] == $past(o_flags[6:5])) else $error("carry or latched flag changed");
  a_illegal_quiet: assert property (o_illegal |-> !o_busy && !o_mem_rd_en && !o_mem_wr_en)
    else $error("refused word caused activity");
  a_addr_held: assert property (o_illegal |-> $stable(o_mem_rd_addr) && $stable(o_mem_wr_addr))
    else $error("refused word moved an address");

  c_par: cover property (o_mem_wr_en);
  c_pop: cover property (o_done && !o_mem_wr_en);
  c_bad: cover property (o_illegal);
endmodule
bind posp_core posp_core_asserts posp_core_asserts_i (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
  .i_mem_rd_data(i_mem_rd_data), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_busy(o_busy), .o_mem_rd_en(o_mem_rd_en), .o_mem_rd_addr(o_mem_rd_addr),
  .o_mem_wr_en(o_mem_wr_en), .o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data), .o_done(o_done),
  .o_illegal(o_illegal), .o_reg_rdata(o_reg_rdata), .o_flags(o_flags));
`default_nettype wire

// ---- tb_posp_core.sv ----
// Self-checking bench for the OR-with-store and stack pop block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_posp_core;
  logic        i_clk_sys = 1'b0, i_rstn = 1'b0, i_instr_valid = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [31:0] i_instr = 32'h0, i_mem_rd_data = 32'h0, o_mem_rd_addr, o_mem_wr_addr, o_mem_wr_data, e32;
  logic [4:0]  i_reg_addr = 5'h0;
  logic [39:0] i_reg_wdata = 40'h0, o_reg_rdata, e40;
  logic        o_busy, o_mem_rd_en, o_mem_wr_en, o_done, o_illegal, rd_d = 1'b0;
  logic [6:0]  o_flags, fl;
  logic [7:0]  e8;
  logic [63:0] e64;
  logic [39:0] rf[0:27];
  logic [39:0] rq[$];
  logic [31:0] aq[$];
  logic [63:0] wq[$];
  logic [7:0]  fq[$];
  int          n_errors = 0, total_checks = 0;

  posp_core posp_core_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_mem_rd_data(i_mem_rd_data), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_busy(o_busy), .o_mem_rd_en(o_mem_rd_en),
    .o_mem_rd_addr(o_mem_rd_addr), .o_mem_wr_en(o_mem_wr_en), .o_mem_wr_addr(o_mem_wr_addr),
    .o_mem_wr_data(o_mem_wr_data), .o_done(o_done), .o_illegal(o_illegal), .o_reg_rdata(o_reg_rdata),
    .o_flags(o_flags));

  always #25 i_clk_sys = ~i_clk_sys;

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    rd_d <= i_reg_rd;
    if (rd_d) begin
      e40 = rq.pop_front();
      `CHK(o_reg_rdata, e40)
    end
    if (o_mem_rd_en) begin
      e32 = aq.pop_front();
      `CHK(o_mem_rd_addr, e32)
      `CHK(o_busy, 1'b1)
    end
    if (o_mem_wr_en) begin
      e64 = wq.pop_front();
      `CHK({o_mem_wr_addr, o_mem_wr_data}, e64)
    end
    if (o_done || o_illegal) begin
      e8 = fq.pop_front();
      `CHK({o_illegal, o_flags}, e8)
    end
  end

  task automatic wrap_up();
    `CHK(rq.size() + aq.size() + wq.size() + fq.size(), 0)
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [39:0] d);
    @(posedge i_clk_sys);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [39:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    rq.push_back(e);
    @(posedge i_clk_sys);
    i_reg_rd   <= 1'b0;
  endtask

  function automatic logic [6:0] nf(input logic [31:0] r, input logic z);
    logic [6:0] f;
    f = fl;
    f[posp_pkg::FLG_N] = r[31];
    f[posp_pkg::FLG_Z] = z;
    f[posp_pkg::FLG_V] = 1'b0;
    f[posp_pkg::FLG_UNDER] = 1'b0;
    return f;
  endfunction

  // Memory word stands from the issue cycle through the execute cycle, garbage afterwards
  task automatic issue(input logic [31:0] w, ea, m, input logic ok);
    @(posedge i_clk_sys);
    i_instr_valid <= 1'b1;
    i_instr       <= w;
    i_mem_rd_data <= m;
    if (ok) aq.push_back(ea);
    fq.push_back({~ok, fl});
    @(posedge i_clk_sys);
    i_instr_valid <= 1'b0;
    @(posedge i_clk_sys);
    i_mem_rd_data <= ~m;
  endtask

  task automatic par(input logic [2:0] d, s1, s3, input logic [7:0] aw, ar, input logic [31:0] eaw, ear, m);
    logic [31:0] r;
    r = rf[s1][31:0] | m;
    wq.push_back({eaw, rf[s3][31:0]});
    rf[d][31:0] = r;
    fl = nf(r, r == 32'h0);
    issue({posp_pkg::PAR_LEAD, posp_pkg::PAR_OPCODE, d, s1, s3, aw, ar}, ear, m, 1'b1);
  endtask

  task automatic pop(input logic f, input logic [4:0] d, input logic [31:0] m);
    logic [31:0] top;
    top = rf[20][31:0];
    if (f) rf[d] = {m, 8'h00};
    else rf[d][31:0] = m;
    rf[20][31:0] = top - 32'h1;
    fl = nf(m, f ? m[31:24] == posp_pkg::FLOAT_ZERO_EXP : m == 32'h0);
    issue({f ? posp_pkg::POP_FLT_OPCODE : posp_pkg::POP_INT_OPCODE, d, 16'h0000}, top, m, 1'b1);
  endtask

  task automatic read_all();
    for (int i = 0; i < 28; i++) rd(5'(i), rf[i]);
    rd(5'h1c, {33'h0, fl});
    rd(5'h1f, 40'h0);
  endtask

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(58));
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    for (int i = 0; i < 28; i++) begin
      rf[i] = 40'({$urandom, $urandom});
      if (i > 7) rf[i][39:32] = 8'h00;
      if (i == 3) rf[i] = 40'h0;
      wr(5'(i), rf[i]);
    end
    fl = 7'h73;
    wr(5'h1c, {33'h0, fl});
    read_all();
    // Store source equals OR destination; post-decrement of store aux
    par(3'h2, 3'h5, 3'h2, 8'haa, 8'h09, rf[10][31:0], rf[9][31:0] + 32'h1, $urandom);
    rf[10][31:0] = rf[10][31:0] - 32'h1;
    // Source and store share one location through index displacement
    par(3'h1, 3'h3, 3'h4, 8'h11, 8'h11, rf[9][31:0] + rf[17][31:0], rf[9][31:0] + rf[17][31:0], 32'h0);
    // Pre-decrement and pre-increment with modify, second index displacement
    par(3'h6, 3'h0, 3'h7, 8'h6c, 8'h5b, rf[12][31:0] - 32'h1, rf[11][31:0] + rf[18][31:0], $urandom);
    rf[12][31:0] = rf[12][31:0] - 32'h1;
    rf[11][31:0] = rf[11][31:0] + rf[18][31:0];
    // Pre-subtract without modify, post-increment
    par(3'h0, 3'h6, 3'h0, 8'h3e, 8'h8d, rf[14][31:0] - rf[18][31:0], rf[13][31:0], $urandom);
    rf[13][31:0] = rf[13][31:0] + 32'h1;
    // Plain aux operand codes ignore displacement
    par(3'h7, 3'h7, 3'h1, 8'hf0, 8'hcf, rf[8][31:0], rf[15][31:0], $urandom);
    pop(1'b0, 5'h1b, $urandom | 32'h80000000);
    pop(1'b0, 5'h08, 32'h0);
    pop(1'b1, 5'h04, 32'h80000000);
    pop(1'b1, 5'h07, 32'h5f2c1302);
    issue({posp_pkg::POP_FLT_OPCODE, 5'h08, 16'h0000}, 32'h0, 32'h0, 1'b0);
    issue({posp_pkg::POP_INT_OPCODE, 5'h01, 16'h0001}, 32'h0, 32'h0, 1'b0);
    issue({posp_pkg::POP_INT_OPCODE, 5'h1c, 16'h0000}, 32'h0, 32'h0, 1'b0);
    issue(32'h0, 32'h0, 32'h0, 1'b0);
    read_all();
    repeat (3) @(posedge i_clk_sys);
    wrap_up();
  end
endmodule
`default_nettype wire
